// >>> rtl/nbr_params.svh
// Function
// (R1) Store four registers of sixteen main plus four status 4-bit characters.
// (R2) Chip number: mask option is high bit, strap pin is low bit.
// (R3) Reset clears control and output flops and the array, bus floats.
// (R4) Controller holds reset at least 32 instruction cycles, 256 clock periods; the testbench's first reset holds 16 clock periods.
// (R5) Command input during execute state two marks a select-address instruction.
// (R6) Only the chip matching bus bits 3..2 becomes selected.
// (R7) Address nibble bits 3..2 are chip number, bits 1..0 register index.
// (R8) Selected chip latches the execute-state-three nibble as character index 0..15.
// (R9) Read main character drives addressed character onto the bus, unchanged.
// (R10) Read status drives status character 0..3 of selected register.
// (R11) Write main character stores the bus nibble into addressed character.
// (R12) Write status stores bus nibble into status character 0..3.
// (R13) Status number and operation come from the operand nibble.
// (R14) Port write loads four output flops, bit 0 on output 0, held.
// (R15) Port write data is taken from the bus in execute state two.
// (R16) Add and subtract memory operands drive the addressed character, unchanged.
// (R17) Command line at fetch state two; chips capture and decode operand nibble.
// (R18) Memory transfers happen in execute states two and three; the code reads, writes and loads the port in execute state two only.
// (R19) Processor sends select-address nibbles at execute states two and three.
// (R20) Processor issues select-address before the instruction using it.
// (R21) Cycle-start once per instruction cycle; states timed from that mark.
// (R22) Eight states per cycle, one per clock, restart after cycle-start.
// (R23) Bus driven only in execute state two of a selected read.
`ifndef NBR_PARAMS_SVH
`define NBR_PARAMS_SVH

`define NBR_CHAR_W 4
`define NBR_REGS 4
`define NBR_MAIN_CHARS 16
`define NBR_STAT_CHARS 4
`define NBR_DEPTH 80
`define NBR_IDX_W 7
`define NBR_STAT_BIT 6

// operand nibble encodings of the memory and port group
`define NBR_OP_WRITE_MAIN 4'h0
`define NBR_OP_PORT_WRITE 4'h1
`define NBR_OP_SUB_MEM 4'h8
`define NBR_OP_READ_MAIN 4'h9
`define NBR_OP_ADD_MEM 4'hb
`define NBR_OP_WRITE_STAT 2'h1
`define NBR_OP_READ_STAT 2'h3

`define NBR_RST_NIBBLE 4'h0
`define NBR_RST_REG 2'h0

`endif

// >>> rtl/nbr_pkg.sv
package nbr_pkg;

    typedef enum logic [2:0] {
        NBR_A1, NBR_A2, NBR_A3, NBR_M1, NBR_M2, NBR_X1, NBR_X2, NBR_X3
    } nbr_phase_t;

    // pin inputs carried together through the synchroniser
    typedef struct packed {
        logic sync;
        logic cmd;
        logic [3:0] data;
        logic strap;
    } nbr_pins_t;

    // selection left behind by a select-address instruction
    typedef struct packed {
        logic sel;
        logic [1:0] reg_idx;
        logic [3:0] char_idx;
    } nbr_sel_t;

endpackage : nbr_pkg

// >>> rtl/nbr_char_array.sv
`timescale 1ns/1ps
`include "nbr_params.svh"
module nbr_char_array (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // write port
    input wire logic wr_en_in,
    input wire logic [`NBR_IDX_W-1:0] wr_idx_in,
    input wire logic [`NBR_CHAR_W-1:0] wr_data_in,
    // read port
    input wire logic [`NBR_IDX_W-1:0] rd_idx_in,
    output logic [`NBR_CHAR_W-1:0] rd_data_out
);

    logic [`NBR_CHAR_W-1:0] mem_ff [`NBR_DEPTH];

    // flop array clears in one edge, well inside the reset the controller must give
    genvar gi;
    generate
        for (gi = 0; gi < `NBR_DEPTH; gi++) begin : g_char
            logic [`NBR_CHAR_W-1:0] nxt_char;
            always_comb begin
                nxt_char = mem_ff[gi];
                if (wr_en_in && wr_idx_in == `NBR_IDX_W'(gi)) begin
                    nxt_char = wr_data_in;
                end
            end
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    mem_ff[gi] <= `NBR_RST_NIBBLE; // R3
                end else begin
                    mem_ff[gi] <= nxt_char;
                end
            end
        end
    endgenerate

    // unused high indices read as zero
    assign rd_data_out = (rd_idx_in < `NBR_IDX_W'(`NBR_DEPTH)) ? mem_ff[rd_idx_in]
                                                               : `NBR_RST_NIBBLE;

endmodule : nbr_char_array

// >>> rtl/nbr_ram_port.sv
`timescale 1ns/1ps
`include "nbr_params.svh"
module nbr_ram_port #(
    // mask option: high bit of the chip number
    parameter logic MASK_CHIP_HI = 1'b0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // processor bus
    input wire logic sync_in,
    input wire logic command_input_in,
    input wire logic [3:0] data_in,
    output logic [3:0] data_out,
    output logic data_oe_out,
    // board strap
    input wire logic chip_number_strap_in,
    // output port
    output logic [3:0] output_port_pins_out
);

    function automatic logic op_is_read(input logic [3:0] op);
        return op == `NBR_OP_READ_MAIN || op == `NBR_OP_ADD_MEM ||
               op == `NBR_OP_SUB_MEM || op[3:2] == `NBR_OP_READ_STAT;
    endfunction : op_is_read

    function automatic logic op_is_status(input logic [3:0] op);
        return op[3:2] == `NBR_OP_WRITE_STAT || op[3:2] == `NBR_OP_READ_STAT;
    endfunction : op_is_status

    // pin synchroniser
    nbr_pkg::nbr_pins_t pins_raw;
    nbr_pkg::nbr_pins_t pins_meta_ff;
    nbr_pkg::nbr_pins_t pins_ff;

    assign pins_raw = '{sync: sync_in, cmd: command_input_in, data: data_in,
                        strap: chip_number_strap_in};

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pins_meta_ff <= '0;
            pins_ff <= '0;
        end else begin
            pins_meta_ff <= pins_raw;
            pins_ff <= pins_meta_ff;
        end
    end

    // strap tied to the negative supply reads as logic one
    logic [1:0] chip_id;
    assign chip_id = {MASK_CHIP_HI, pins_ff.strap}; // R2

    // instruction cycle sequencer
    nbr_pkg::nbr_phase_t phase_ff;
    nbr_pkg::nbr_phase_t nxt_phase;

    always_comb begin
        if (pins_ff.sync) begin
            nxt_phase = nbr_pkg::NBR_A1; // R21 R22
        end else begin
            unique case (phase_ff)
                nbr_pkg::NBR_A1: nxt_phase = nbr_pkg::NBR_A2;
                nbr_pkg::NBR_A2: nxt_phase = nbr_pkg::NBR_A3;
                nbr_pkg::NBR_A3: nxt_phase = nbr_pkg::NBR_M1;
                nbr_pkg::NBR_M1: nxt_phase = nbr_pkg::NBR_M2;
                nbr_pkg::NBR_M2: nxt_phase = nbr_pkg::NBR_X1;
                nbr_pkg::NBR_X1: nxt_phase = nbr_pkg::NBR_X2;
                nbr_pkg::NBR_X2: nxt_phase = nbr_pkg::NBR_X3;
                nbr_pkg::NBR_X3: nxt_phase = nbr_pkg::NBR_A1; // R22
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phase_ff <= nbr_pkg::NBR_X3;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // selection state
    nbr_pkg::nbr_sel_t sel_ff;
    nbr_pkg::nbr_sel_t nxt_sel;
    logic src_pend_ff;
    logic nxt_src_pend;
    logic src_seen;

    assign src_seen = phase_ff == nbr_pkg::NBR_X2 && pins_ff.cmd; // R5

    always_comb begin
        nxt_sel = sel_ff;
        nxt_src_pend = 1'b0;
        if (src_seen) begin
            // every chip on the line re-evaluates, so a miss deselects
            nxt_sel.sel = pins_ff.data[3:2] == chip_id; // R6 R7
            nxt_src_pend = nxt_sel.sel;
            if (nxt_sel.sel) begin
                nxt_sel.reg_idx = pins_ff.data[1:0]; // R7
            end
        end
        if (phase_ff == nbr_pkg::NBR_X3 && src_pend_ff) begin
            nxt_sel.char_idx = pins_ff.data; // R8
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_ff <= '{sel: 1'b0, reg_idx: `NBR_RST_REG, char_idx: `NBR_RST_NIBBLE};
            src_pend_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
            src_pend_ff <= nxt_src_pend;
        end
    end

    // operand decode, one instruction at a time
    logic [3:0] op_ff;
    logic [3:0] nxt_op;
    logic op_vld_ff;
    logic nxt_op_vld;

    always_comb begin
        nxt_op = op_ff;
        nxt_op_vld = op_vld_ff;
        if (phase_ff == nbr_pkg::NBR_M2) begin
            // a select in the same cycle cannot exist, it is only seen in X2
            nxt_op_vld = pins_ff.cmd && sel_ff.sel; // R17
            if (pins_ff.cmd) begin
                nxt_op = pins_ff.data; // R13 R17
            end
        end else if (phase_ff == nbr_pkg::NBR_X3 || pins_ff.sync) begin
            nxt_op_vld = 1'b0; // R18
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            op_ff <= `NBR_RST_NIBBLE;
            op_vld_ff <= 1'b0;
        end else begin
            op_ff <= nxt_op;
            op_vld_ff <= nxt_op_vld;
        end
    end

    // character array
    logic [`NBR_IDX_W-1:0] arr_idx;
    logic [3:0] arr_rd;
    logic arr_wr_en;
    logic in_x2;

    assign in_x2 = phase_ff == nbr_pkg::NBR_X2 && op_vld_ff;

    // status characters sit above the 64 main characters
    assign arr_idx = op_is_status(op_ff)
        ? {1'b1, 2'h0, sel_ff.reg_idx, op_ff[1:0]}   // R10 R12
        : {1'b0, sel_ff.reg_idx, sel_ff.char_idx};   // R1 R8

    assign arr_wr_en = in_x2 && (op_ff == `NBR_OP_WRITE_MAIN ||
                                 op_ff[3:2] == `NBR_OP_WRITE_STAT); // R11 R12 R18

    nbr_char_array u_array (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_en_in(arr_wr_en),
        .wr_idx_in(arr_idx),
        .wr_data_in(pins_ff.data),
        .rd_idx_in(arr_idx),
        .rd_data_out(arr_rd)
    );

    // bus output and port
    logic [3:0] rd_data_ff;
    logic [3:0] nxt_rd_data;
    logic [3:0] port_ff;
    logic [3:0] nxt_port;

    always_comb begin
        nxt_rd_data = rd_data_ff;
        nxt_port = port_ff;
        if (phase_ff == nbr_pkg::NBR_X1 && op_vld_ff && op_is_read(op_ff)) begin
            nxt_rd_data = arr_rd; // R9 R10 R16
        end
        if (in_x2 && op_ff == `NBR_OP_PORT_WRITE) begin
            nxt_port = pins_ff.data; // R14 R15
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_ff <= `NBR_RST_NIBBLE; // R3
            port_ff <= `NBR_RST_NIBBLE;
        end else begin
            rd_data_ff <= nxt_rd_data;
            port_ff <= nxt_port;
        end
    end

    assign data_out = rd_data_ff;
    assign data_oe_out = in_x2 && op_is_read(op_ff); // R3 R23
    assign output_port_pins_out = port_ff; // R14

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_src_hit;
        phase_ff == nbr_pkg::NBR_X2 && pins_ff.cmd && pins_ff.data[3:2] == chip_id;
    endsequence

    sequence s_decode;
        phase_ff == nbr_pkg::NBR_M2 && pins_ff.cmd && sel_ff.sel;
    endsequence

    sequence s_port_slot;
        phase_ff == nbr_pkg::NBR_X2 && op_vld_ff && op_ff == `NBR_OP_PORT_WRITE;
    endsequence

    property p_reset_float;
        @(posedge clk_in) disable iff (1'b0)
        rst_in |-> !data_oe_out && output_port_pins_out == 4'h0;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("bus or port active in reset"); // R3

    property p_sync_restart;
        pins_ff.sync |=> phase_ff == nbr_pkg::NBR_A1;
    endproperty
    a_sync_restart: assert property (p_sync_restart) else $error("no restart after sync"); // R22

    property p_advance;
        !pins_ff.sync && phase_ff == nbr_pkg::NBR_M2 |=> phase_ff == nbr_pkg::NBR_X1 ##1
            (pins_ff.sync || phase_ff == nbr_pkg::NBR_X2);
    endproperty
    a_advance: assert property (p_advance) else $error("state did not advance"); // R22

    property p_src_select;
        s_src_hit |=> sel_ff.sel && sel_ff.reg_idx == $past(pins_ff.data[1:0]);
    endproperty
    a_src_select: assert property (p_src_select) else $error("select not taken"); // R6

    property p_char_latch;
        s_src_hit ##1 phase_ff == nbr_pkg::NBR_X3 |=> sel_ff.char_idx == $past(pins_ff.data);
    endproperty
    a_char_latch: assert property (p_char_latch) else $error("character index not latched"); // R8

    property p_decode;
        s_decode |=> op_vld_ff && op_ff == $past(pins_ff.data);
    endproperty
    a_decode: assert property (p_decode) else $error("operand not decoded"); // R17

    property p_drive_slot;
        data_oe_out |-> phase_ff == nbr_pkg::NBR_X2 && $past(phase_ff) == nbr_pkg::NBR_X1
            && !arr_wr_en;
    endproperty
    a_drive_slot: assert property (p_drive_slot) else $error("bus driven outside slot"); // R23

    property p_port_load;
        s_port_slot |=> output_port_pins_out == $past(pins_ff.data);
    endproperty
    a_port_load: assert property (p_port_load) else $error("port not loaded"); // R15

    property p_port_hold;
        !$stable(output_port_pins_out) |-> $past(op_ff) == `NBR_OP_PORT_WRITE
            && $past(phase_ff) == nbr_pkg::NBR_X2;
    endproperty
    a_port_hold: assert property (p_port_hold) else $error("port changed without write"); // R14

    property p_read_value;
        phase_ff == nbr_pkg::NBR_X1 && op_vld_ff && op_is_read(op_ff) && !pins_ff.sync
            |=> data_oe_out && data_out == $past(arr_rd);
    endproperty
    a_read_value: assert property (p_read_value) else $error("wrong read data"); // R9

    sequence s_write_slot;
        phase_ff == nbr_pkg::NBR_X2 && op_vld_ff
            && (op_ff == `NBR_OP_WRITE_MAIN || op_ff[3:2] == `NBR_OP_WRITE_STAT);
    endsequence

    // the index does not move in X3, so the read port shows the freshly stored nibble
    property p_write_store;
        s_write_slot |=> arr_rd == $past(pins_ff.data);
    endproperty
    a_write_store: assert property (p_write_store) else $error("write not stored"); // R11

    // a select naming another chip must drop this one, or a stale chip answers
    property p_deselect;
        phase_ff == nbr_pkg::NBR_X2 && pins_ff.cmd && pins_ff.data[3:2] != chip_id
            |=> !sel_ff.sel;
    endproperty
    a_deselect: assert property (p_deselect) else $error("chip stayed selected"); // R6

    property p_ignore_unselected;
        phase_ff == nbr_pkg::NBR_M2 && !sel_ff.sel |=> !op_vld_ff;
    endproperty
    a_ignore_unselected: assert property (p_ignore_unselected) else $error("op taken unselected"); // R17

    // a longer drive would collide with the processor taking the bus back in X3
    property p_drive_pulse;
        data_oe_out |=> !data_oe_out;
    endproperty
    a_drive_pulse: assert property (p_drive_pulse) else $error("bus driven too long"); // R23

endmodule : nbr_ram_port

// >>> verif/nbr_cpu_model.sv
`timescale 1ns/1ps
// processor side: one instruction per eight-state cycle, sync in its last state
module nbr_cpu_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // request: kind 0 idle, 1 select, 2 memory or port op
    input wire logic [1:0] kind_in,
    input wire logic [3:0] a_in,
    input wire logic [3:0] b_in,
    // processor pins
    output logic sync_out,
    output logic cmd_out,
    output logic [3:0] data_out,
    output logic [2:0] ph_out
);
    logic [1:0] kind_ff;
    logic [3:0] a_ff;
    logic [3:0] b_ff;
    logic [2:0] nph;

    assign nph = ph_out + 3'h1;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ph_out <= 3'h0;
            sync_out <= 1'b0;
            cmd_out <= 1'b0;
            data_out <= 4'h0;
            kind_ff <= 2'h0;
            a_ff <= 4'h0;
            b_ff <= 4'h0;
        end else begin
            ph_out <= nph;
            sync_out <= (nph == 3'h7);
            if (ph_out == 3'h7) begin
                kind_ff <= kind_in;
                a_ff <= a_in;
                b_ff <= b_in;
            end
            cmd_out <= (kind_ff == 2'h1 && nph == 3'h6) || (kind_ff == 2'h2 && nph == 3'h4);
            // a released bus does not keep its last value
            if (kind_ff == 2'h1 && nph == 3'h6) begin
                data_out <= a_ff;
            end else if (kind_ff == 2'h1 && nph == 3'h7) begin
                data_out <= b_ff;
            end else if (kind_ff == 2'h2 && nph == 3'h4) begin
                data_out <= a_ff;
            end else if (kind_ff == 2'h2 && nph == 3'h6) begin
                data_out <= b_ff;
            end else begin
                data_out <= ~data_out;
            end
        end
    end
endmodule : nbr_cpu_model

// >>> verif/nbr_ram_port_tb.sv
`timescale 1ns/1ps
module nbr_ram_port_tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic strap = 1'b1;
    logic [1:0] kind = 2'h0;
    logic [3:0] a = 4'h0;
    logic [3:0] b = 4'h0;
    logic sync, cmd, oe;
    logic [3:0] bus, rd_data, port, got;
    logic [2:0] ph;
    int n_mismatch = 0;
    int check_count = 0;
    int n_oe = 0;

    always #50 clk_in = ~clk_in;

    nbr_cpu_model cpu (.clk_in(clk_in), .rst_in(rst_in), .kind_in(kind), .a_in(a),
        .b_in(b), .sync_out(sync), .cmd_out(cmd), .data_out(bus), .ph_out(ph));

    // mask bit 1 and strap 1 make this chip number 3
    nbr_ram_port #(.MASK_CHIP_HI(1'b1)) uut (.clk_in(clk_in), .rst_in(rst_in),
        .sync_in(sync), .command_input_in(cmd), .data_in(bus), .data_out(rd_data),
        .data_oe_out(oe), .chip_number_strap_in(strap), .output_port_pins_out(port));

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] seen);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one instruction cycle, then watch the bus long enough for the delayed answer
    task automatic instr(input logic [1:0] k, input logic [3:0] x, input logic [3:0] y);
        n_oe = 0;
        got = 4'h0;
        do @(negedge clk_in); while (ph !== 3'h6);
        @(posedge clk_in);
        kind <= k;
        a <= x;
        b <= y;
        @(posedge clk_in);
        kind <= 2'h0;
        repeat (20) begin
            @(negedge clk_in);
            if (oe === 1'b1) begin
                n_oe++;
                got = rd_data;
            end
        end
    endtask : instr

    task automatic sel(input logic [1:0] chip, input logic [1:0] r, input logic [3:0] ch);
        instr(2'h1, {chip, r}, ch);
    endtask : sel

    task automatic rd(input string what, input logic [3:0] code, input logic [3:0] exp);
        instr(2'h2, code, 4'h0);
        chk({what, " drive"}, 4'h1, n_oe[3:0]);
        chk(what, exp, got);
    endtask : rd

    task automatic no_rd(input string what, input logic [3:0] code);
        instr(2'h2, code, 4'h0);
        chk(what, 4'h0, n_oe[3:0]);
    endtask : no_rd

    task automatic t_reset;
        chk("port after reset", 4'h0, port);
        no_rd("read before select", 4'h9);
        sel(2'h3, 2'h0, 4'h5);
        rd("cleared char", 4'h9, 4'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_main;
        sel(2'h3, 2'h2, 4'hf);
        instr(2'h2, 4'h0, 4'ha);
        sel(2'h3, 2'h2, 4'he);
        instr(2'h2, 4'h0, 4'h5);
        sel(2'h3, 2'h2, 4'hf);
        rd("read main", 4'h9, 4'ha);
        rd("add operand", 4'hb, 4'ha);
        rd("sub operand", 4'h8, 4'ha);
        rd("read after operands", 4'h9, 4'ha);
        sel(2'h3, 2'h2, 4'he);
        rd("neighbour char", 4'h9, 4'h5);
        $display("test main done");
    endtask : t_main

    task automatic t_status;
        for (int s = 0; s < 4; s++) begin
            sel(2'h3, 2'h1, 4'h7);
            instr(2'h2, 4'h4 + s[3:0], 4'h3 + s[3:0]);
        end
        for (int s = 0; s < 4; s++) begin
            sel(2'h3, 2'h1, 4'h0);
            rd("status", 4'hc + s[3:0], 4'h3 + s[3:0]);
        end
        sel(2'h3, 2'h1, 4'h7);
        rd("main beside status", 4'h9, 4'h0);
        sel(2'h3, 2'h0, 4'h7);
        rd("status other reg", 4'hc, 4'h0);
        $display("test status done");
    endtask : t_status

    task automatic t_port;
        sel(2'h3, 2'h0, 4'h0);
        instr(2'h2, 4'h1, 4'h6);
        chk("port", 4'h6, port);
        sel(2'h1, 2'h0, 4'h0);
        instr(2'h2, 4'h1, 4'h9);
        chk("port held", 4'h6, port);
        no_rd("read other chip", 4'h9);
        $display("test port done");
    endtask : t_port

    task automatic t_strap;
        @(posedge clk_in);
        strap <= 1'b0;
        sel(2'h2, 2'h2, 4'hf);
        rd("strap chip 2", 4'h9, 4'ha);
        sel(2'h3, 2'h2, 4'hf);
        no_rd("strap chip 3", 4'h9);
        @(posedge clk_in);
        strap <= 1'b1;
        $display("test strap done");
    endtask : t_strap

    task automatic t_reset2;
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (256) @(posedge clk_in);
        rst_in <= 1'b0;
        chk("port after reset", 4'h0, port);
        sel(2'h3, 2'h2, 4'hf);
        rd("char after reset", 4'h9, 4'h0);
        $display("test reset2 done");
    endtask : t_reset2

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_main();
        t_status();
        t_port();
        t_strap();
        t_reset2();
        complete_run();
    end

    initial begin
        #(20000 * 100);
        n_mismatch++;
        complete_run();
    end
endmodule : nbr_ram_port_tb
